// *** logic/pt_blocks.sv ***
// Function blocks: generator, on-delay, counters, pulse timer, comparator
module pt_blocks
	import pt_pkg::*;
#(
	parameter int TICK_CYCLES = pt_pkg::TICK_CYC
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	// Wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	// Block inputs
	input  wire logic                  sqw_enable,
	input  wire logic                  sqw_reset,
	input  wire logic                  lod_trigger_input,
	input  wire logic                  lod_reset,
	input  wire logic                  up_count_pulse_input,
	input  wire logic                  up_reset,
	input  wire logic                  dn_count_pulse_input,
	input  wire logic                  dn_reset,
	input  wire logic                  spt_trigger_input,
	input  wire logic                  spt_reset,
	input  wire logic [8*pt_pkg::NCHAN-1:0] input_channels,
	// Block outputs
	output logic                       sqw_out,
	output logic                       lod_out,
	output logic                       up_out,
	output logic                       dn_out,
	output logic                       spt_out,
	output logic [pt_pkg::NOUT-1:0]    output_points,
	output logic [pt_pkg::NREL-1:0]    internal_relay_bits
);
	import pt_pkg::*;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	logic [31:0] sqw_cfg_reg, lod_cfg_reg, spt_cfg_reg;
	logic [31:0] up_target_reg, dn_preset_reg, cmp_cfg_reg, cmp_route_reg;
	logic [19:0] up_count_reg, dn_count_reg;
	logic        dn_load_reg;
	logic        sqw_prev_reg, lod_prev_reg, up_prev_reg, dn_prev_reg;
	logic        spt_prev_reg;
	logic        tick_sec, tick_min, tick_hr;
	logic        cmp_res_reg;
	pt_sq_t      sq_state_reg;
	pt_ld_t      ld_state_reg;
	pt_sp_t      sp_state_reg;
	logic        wr_en;
	logic [19:0] up_target;

	// Shared hundredth-of-unit ticks
	pt_tick #(.DIV(TICK_CYCLES)) u_tick_sec (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_pulse  (1'b1),
		.out_pulse (tick_sec)
	);
	pt_tick #(.DIV(MIN_DIV)) u_tick_min (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_pulse  (tick_sec),
		.out_pulse (tick_min)
	);
	pt_tick #(.DIV(HR_DIV)) u_tick_hr (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_pulse  (tick_min),
		.out_pulse (tick_hr)
	);

	function automatic logic tick_of(input logic [31:0] cfg,
		input logic s, input logic m, input logic h);
		case (cfg[F_UNIT +: 3])
			UNIT_HOUR: tick_of = h;
			UNIT_MIN:  tick_of = m;
			default:   tick_of = s;
		endcase
	endfunction : tick_of

	// Register bus
	// Write lands at the edge where the master samples ack high
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sqw_cfg_reg   <= RST_TIME_CFG;
			lod_cfg_reg   <= RST_TIME_CFG;
			spt_cfg_reg   <= RST_TIME_CFG;
			up_target_reg <= RST_TARGET;
			dn_preset_reg <= RST_TARGET;
			cmp_cfg_reg   <= RST_CMP_CFG;
			cmp_route_reg <= RST_ROUTE;
		end else if (wr_en) begin
			case (wb_adr_i)
				A_SQW_CFG:   sqw_cfg_reg   <= pt_wmask(sqw_cfg_reg,
					wb_dat_i, wb_sel_i);
				A_LOD_CFG:   lod_cfg_reg   <= pt_wmask(lod_cfg_reg,
					wb_dat_i, wb_sel_i);
				A_SPT_CFG:   spt_cfg_reg   <= pt_wmask(spt_cfg_reg,
					wb_dat_i, wb_sel_i);
				A_UP_TARGET: up_target_reg <= pt_wmask(up_target_reg,
					wb_dat_i, wb_sel_i);
				A_DN_PRESET: dn_preset_reg <= pt_wmask(dn_preset_reg,
					wb_dat_i, wb_sel_i);
				A_CMP_CFG:   cmp_cfg_reg   <= pt_wmask(cmp_cfg_reg,
					wb_dat_i, wb_sel_i);
				A_CMP_ROUTE: cmp_route_reg <= pt_wmask(cmp_route_reg,
					wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wb_dat_o <= 32'h0000_0000;
		end else begin
			case (wb_adr_i)
				A_SQW_CFG:   wb_dat_o <= sqw_cfg_reg;
				A_LOD_CFG:   wb_dat_o <= lod_cfg_reg;
				A_SPT_CFG:   wb_dat_o <= spt_cfg_reg;
				A_UP_TARGET: wb_dat_o <= up_target_reg;
				A_DN_PRESET: wb_dat_o <= dn_preset_reg;
				A_CMP_CFG:   wb_dat_o <= cmp_cfg_reg;
				A_CMP_ROUTE: wb_dat_o <= cmp_route_reg;
				A_STATUS:    wb_dat_o <= {26'h000_0000, cmp_res_reg,
					spt_out, dn_out, up_out, lod_out, sqw_out};
				A_UP_COUNT:  wb_dat_o <= {12'h000, up_count_reg};
				A_DN_COUNT:  wb_dat_o <= {12'h000, dn_count_reg};
				default:     wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Previous samples for edge detection
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sqw_prev_reg <= 1'b0;
			lod_prev_reg <= 1'b0;
			up_prev_reg  <= 1'b0;
			dn_prev_reg  <= 1'b0;
			spt_prev_reg <= 1'b0;
		end else begin
			sqw_prev_reg <= sqw_enable;
			lod_prev_reg <= lod_trigger_input;
			up_prev_reg  <= up_count_pulse_input;
			dn_prev_reg  <= dn_count_pulse_input;
			spt_prev_reg <= spt_trigger_input;
		end
	end

	// Square-wave generator
	logic        sq_done;
	logic [13:0] sq_elapsed;
	pt_timer u_sq_timer (
		.sys_clk (sys_clk),
		.reset   (reset),
		.clear   (sq_state_reg != SQ_RUN || sq_done),
		.run     (1'b1),
		.tick    (tick_of(sqw_cfg_reg, tick_sec, tick_min, tick_hr)),
		.limit   (pt_lim(sqw_cfg_reg[13:0])),
		.elapsed (sq_elapsed),
		.done    (sq_done)
	);

	always_ff @(posedge sys_clk) begin
		if (reset || sqw_reset || !sqw_enable) begin
			sq_state_reg <= SQ_IDLE;
			sqw_out      <= 1'b0;
		end else begin
			case (sq_state_reg)
				SQ_IDLE: begin
					sq_state_reg <= SQ_RUN;
					sqw_out      <= 1'b0;
				end
				SQ_RUN: if (sq_done) begin
					sqw_out <= !sqw_out;
				end
				default: sq_state_reg <= SQ_IDLE;
			endcase
		end
	end

	// Latching on-delay timer
	logic        ld_done;
	logic [13:0] ld_elapsed;
	pt_timer u_ld_timer (
		.sys_clk (sys_clk),
		.reset   (reset),
		.clear   (lod_reset || ld_state_reg == LD_IDLE),
		.run     (ld_state_reg == LD_TIME),
		.tick    (tick_of(lod_cfg_reg, tick_sec, tick_min, tick_hr)),
		.limit   (pt_lim(lod_cfg_reg[13:0])),
		.elapsed (ld_elapsed),
		.done    (ld_done)
	);

	always_ff @(posedge sys_clk) begin
		if (reset || lod_reset) begin
			ld_state_reg <= LD_IDLE;
			lod_out      <= 1'b0;
		end else begin
			case (ld_state_reg)
				LD_IDLE: if (lod_trigger_input && !lod_prev_reg) begin
					ld_state_reg <= LD_TIME;
				end
				LD_TIME: if (ld_done) begin
					ld_state_reg <= LD_ON;
					lod_out      <= 1'b1;
				end
				LD_ON:   lod_out <= 1'b1;
				default: ld_state_reg <= LD_IDLE;
			endcase
		end
	end

	// Up counter
	assign up_target = (up_target_reg[19:0] < CNT_MIN) ? CNT_MIN :
		(up_target_reg[19:0] > CNT_MAX) ? CNT_MAX : up_target_reg[19:0];

	always_ff @(posedge sys_clk) begin
		if (reset || up_reset) begin
			up_count_reg <= 20'h0_0000;
			up_out       <= 1'b0;
		end else if (up_count_pulse_input && !up_prev_reg
			&& up_count_reg < CNT_MAX) begin
			up_count_reg <= up_count_reg + 20'h0_0001;
			up_out <= (up_count_reg + 20'h0_0001 >= up_target);
		end else begin
			up_out <= (up_count_reg >= up_target);
		end
	end

	// Down counter; a preset write loads the count
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dn_load_reg <= 1'b0;
		end else begin
			dn_load_reg <= wr_en && wb_adr_i == A_DN_PRESET;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || dn_reset) begin
			dn_count_reg <= 20'h0_0000;
			dn_out       <= 1'b0;
		end else if (dn_load_reg) begin
			dn_count_reg <= (dn_preset_reg[19:0] > CNT_MAX) ? CNT_MAX
				: dn_preset_reg[19:0];
			dn_out       <= 1'b0;
		end else if (dn_count_pulse_input && !dn_prev_reg
			&& dn_count_reg != 20'h0_0000) begin
			dn_count_reg <= dn_count_reg - 20'h0_0001;
			dn_out <= (dn_count_reg == 20'h0_0001);
		end
	end

	// Single-pulse timer, retriggerable
	logic        sp_done;
	logic [13:0] sp_elapsed;
	logic        sp_edge;
	assign sp_edge = spt_trigger_input && !spt_prev_reg;
	pt_timer u_sp_timer (
		.sys_clk (sys_clk),
		.reset   (reset),
		.clear   (spt_reset || sp_edge || sp_state_reg == SP_IDLE),
		.run     (sp_state_reg == SP_PULSE),
		.tick    (tick_of(spt_cfg_reg, tick_sec, tick_min, tick_hr)),
		.limit   (pt_lim(spt_cfg_reg[13:0])),
		.elapsed (sp_elapsed),
		.done    (sp_done)
	);

	always_ff @(posedge sys_clk) begin
		if (reset || spt_reset) begin
			sp_state_reg <= SP_IDLE;
			spt_out      <= 1'b0;
		end else if (sp_edge) begin
			sp_state_reg <= SP_PULSE;
			spt_out      <= 1'b1;
		end else begin
			case (sp_state_reg)
				SP_IDLE:  spt_out <= 1'b0;
				SP_PULSE: if (sp_done) begin
					sp_state_reg <= SP_IDLE;
					spt_out      <= 1'b0;
				end
				default:  sp_state_reg <= SP_IDLE;
			endcase
		end
	end

	// Voltage threshold comparator, values in tenths of a volt
	logic [7:0] op_a, op_b;
	logic       cmp_now;
	always_comb begin
		op_a = cmp_cfg_reg[F_A_SEL] ?
			input_channels[8*32'(cmp_cfg_reg[F_A_CH +: 4]) +: 8]
			: {1'b0, (cmp_cfg_reg[6:0] > ANA_MAX) ? ANA_MAX
			: cmp_cfg_reg[6:0]};
		op_b = cmp_cfg_reg[F_B_SEL] ?
			input_channels[8*32'(cmp_cfg_reg[F_B_CH +: 4]) +: 8]
			: {1'b0, (cmp_cfg_reg[F_B_CONST +: 7] > ANA_MAX) ? ANA_MAX
			: cmp_cfg_reg[F_B_CONST +: 7]};
		// A missing channel reads as zero; a constant operand is kept
		if (cmp_cfg_reg[F_A_SEL]
			&& cmp_cfg_reg[F_A_CH +: 4] >= 4'(NCHAN)) begin
			op_a = 8'h00;
		end
		if (cmp_cfg_reg[F_B_SEL]
			&& cmp_cfg_reg[F_B_CH +: 4] >= 4'(NCHAN)) begin
			op_b = 8'h00;
		end
		case (cmp_cfg_reg[F_REL +: 2])
			REL_GT:  cmp_now = op_a >  op_b;
			REL_LT:  cmp_now = op_a <  op_b;
			REL_GE:  cmp_now = op_a >= op_b;
			REL_LE:  cmp_now = op_a <= op_b;
			default: cmp_now = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cmp_res_reg         <= 1'b0;
			output_points       <= '0;
			internal_relay_bits <= '0;
		end else begin
			cmp_res_reg <= cmp_now;
			for (int i = 0; i < NOUT; i++) begin
				output_points[i] <= cmp_now
					&& cmp_route_reg[7:0] == 8'(i);
			end
			for (int i = 0; i < NREL; i++) begin
				internal_relay_bits[i] <= cmp_now
					&& cmp_route_reg[7:0] == 8'(i + NOUT);
			end
		end
	end

	AST_SQ_HALT: assert property (
		!sqw_enable |=> !sqw_out && sq_state_reg == SQ_IDLE)
		else $error("generator not halted by enable low");
	AST_SQ_RESET: assert property (
		sqw_reset[*2] |=> !sqw_out)
		else $error("generator output not held low in reset");
	AST_SQ_FIRST: assert property (
		sqw_enable && !sqw_prev_reg && !sqw_reset |=> sq_elapsed == 0)
		else $error("generator timer not restarted on enable edge");
	AST_LD_HOLD: assert property (
		lod_out && !lod_reset |=> lod_out)
		else $error("latched on-delay output dropped");
	AST_LD_RESET: assert property (
		lod_reset |=> !lod_out ##0 ld_elapsed == 0)
		else $error("on-delay reset did not clear");
	AST_UP_RESET: assert property (
		up_reset |=> up_count_reg == 0 && !up_out)
		else $error("up counter reset failed");
	AST_UP_EDGE: assert property (
		!up_reset && up_count_pulse_input && !up_prev_reg
		&& up_count_reg < CNT_MAX
		|=> up_count_reg == $past(up_count_reg) + 20'h0_0001)
		else $error("up counter missed an edge");
	AST_UP_STEADY: assert property (
		!up_reset && !(up_count_pulse_input && !up_prev_reg)
		|=> $stable(up_count_reg))
		else $error("up counter moved without edge");
	AST_DN_ZERO: assert property (
		!dn_reset && !dn_load_reg && dn_count_reg == 20'h0_0001
		&& dn_count_pulse_input && !dn_prev_reg |=> dn_out)
		else $error("down counter output not set at zero");
	AST_DN_RESET: assert property (
		dn_reset |=> dn_count_reg == 0 && !dn_out)
		else $error("down counter reset failed");
	AST_SP_EDGE: assert property (
		sp_edge && !spt_reset |=> spt_out ##0 sp_elapsed == 0)
		else $error("pulse not started on trigger edge");
	AST_SP_RESET: assert property (
		spt_reset |=> !spt_out)
		else $error("pulse not cut by reset");
	AST_CMP_ROUTE: assert property (
		cmp_route_reg[7:0] < 8'(NOUT)
		|=> output_points == ((8'h01 << $past(cmp_route_reg[2:0]))
		& {8{$past(cmp_now)}}))
		else $error("comparator result not routed");
endmodule : pt_blocks

// *** logic/pt_pkg.sv ***
// Constants, register map and helpers for the controller function blocks
// Operation
// - Square-wave period takes 0.01 to 99.99 in hours, minutes or seconds.
// - Enabled generator toggles output every period; enable low halts, output zero.
// - Enable rising edge restarts timer from zero; first high after one period.
// - Generator reset holds output zero; release with enable restarts from low.
// - On-delay trigger rising edge starts timer; output one after full delay.
// - Latched on-delay output ignores trigger; only reset clears output and time.
// - On-delay reset beats trigger: output zero and timer stopped.
// - On-delay setting takes 0.01 to 99.99 in hours, minutes or seconds.
// - Up counter reset dominates: count zero and output low together.
// - Up counter adds one only on count input rising edges.
// - Up counter output asserts once count reaches the target.
// - Counter targets are six decimal digits, 1 to 999999; a down preset of 0 loads a zero count.
// - Down counter reset wins: count cleared and output low together.
// - Down counter output asserts when count reaches zero by counting down.
// - Single pulse: each trigger rising edge gives output high for set duration.
// - Single-pulse reset forces output zero, cutting any pulse short.
// - Single-pulse duration takes 0.01 to 99.99 in seconds, minutes or hours.
// - Each comparator operand is a constant 0.0 to 10.0 or an analog channel.
// - Comparator applies greater, less, greater-equal or less-equal; one if true.
// - Comparator result routes to any output point or internal relay bit.
package pt_pkg;
	localparam int          CLK_HZ       = 25_000_000;
	localparam int          TICK_MS      = 10;
	localparam int          TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
	localparam int          MIN_DIV      = 60;
	localparam int          HR_DIV       = 60;
	localparam logic [13:0] SET_MIN      = 14'h0001;
	localparam logic [13:0] SET_MAX      = 14'h270F;
	localparam logic [19:0] CNT_MIN      = 20'h0_0001;
	localparam logic [19:0] CNT_MAX      = 20'hF_423F;
	localparam logic [6:0]  ANA_MAX      = 7'h64;
	localparam int          NCHAN        = 12;
	localparam int          NOUT         = 8;
	localparam int          NREL         = 127;
	localparam logic [7:0]  ROUTE_MAX    = 8'h86;
	localparam logic [2:0]  UNIT_HOUR    = 3'h1;
	localparam logic [2:0]  UNIT_MIN     = 3'h2;
	localparam logic [2:0]  UNIT_SEC     = 3'h4;
	localparam int          F_UNIT       = 16;
	localparam int          F_A_SEL      = 7;
	localparam int          F_A_CH       = 8;
	localparam int          F_B_CONST    = 12;
	localparam int          F_B_SEL      = 19;
	localparam int          F_B_CH       = 20;
	localparam int          F_REL        = 24;
	localparam logic [1:0]  REL_GT       = 2'h0;
	localparam logic [1:0]  REL_LT       = 2'h1;
	localparam logic [1:0]  REL_GE       = 2'h2;
	localparam logic [1:0]  REL_LE       = 2'h3;
	localparam logic [7:0]  A_SQW_CFG    = 8'h00;
	localparam logic [7:0]  A_LOD_CFG    = 8'h04;
	localparam logic [7:0]  A_SPT_CFG    = 8'h08;
	localparam logic [7:0]  A_UP_TARGET  = 8'h0C;
	localparam logic [7:0]  A_DN_PRESET  = 8'h10;
	localparam logic [7:0]  A_CMP_CFG    = 8'h14;
	localparam logic [7:0]  A_CMP_ROUTE  = 8'h18;
	localparam logic [7:0]  A_STATUS     = 8'h1C;
	localparam logic [7:0]  A_UP_COUNT   = 8'h20;
	localparam logic [7:0]  A_DN_COUNT   = 8'h24;
	localparam logic [31:0] RST_TIME_CFG = 32'h0004_0064;
	localparam logic [31:0] RST_TARGET   = 32'h0000_0001;
	localparam logic [31:0] RST_CMP_CFG  = 32'h0000_0000;
	localparam logic [31:0] RST_ROUTE    = 32'h0000_0000;

	typedef enum logic [1:0] {SQ_IDLE = 2'b01, SQ_RUN = 2'b10} pt_sq_t;
	typedef enum logic [2:0] {
		LD_IDLE = 3'b001, LD_TIME = 3'b010, LD_ON = 3'b100
	} pt_ld_t;
	typedef enum logic [1:0] {SP_IDLE = 2'b01, SP_PULSE = 2'b10} pt_sp_t;

	// Byte-lane merge of a bus write
	function automatic logic [31:0] pt_wmask(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : pt_wmask

	// Clamp a time setting into the legal hundredths range
	function automatic logic [13:0] pt_lim(input logic [13:0] v);
		if (v < SET_MIN) begin
			return SET_MIN;
		end
		if (v > SET_MAX) begin
			return SET_MAX;
		end
		return v;
	endfunction : pt_lim
endpackage : pt_pkg

// *** logic/pt_tick.sv ***
// Prescaler that emits one pulse per DIV input pulses
module pt_tick #(
	parameter int DIV = 60
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// Pulse in and divided pulse out
	input  wire logic in_pulse,
	output logic      out_pulse
);
	logic [31:0] cnt_reg;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cnt_reg   <= 32'h0000_0000;
			out_pulse <= 1'b0;
		end else begin
			out_pulse <= 1'b0;
			if (in_pulse) begin
				if (cnt_reg == 32'(DIV - 1)) begin
					cnt_reg   <= 32'h0000_0000;
					out_pulse <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 32'h0000_0001;
				end
			end
		end
	end
endmodule : pt_tick

// *** logic/pt_timer.sv ***
// Elapsed-time counter in hundredths of the selected unit
module pt_timer (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Control
	input  wire logic        clear,
	input  wire logic        run,
	input  wire logic        tick,
	input  wire logic [13:0] limit,
	// State
	output logic      [13:0] elapsed,
	output logic             done
);
	always_ff @(posedge sys_clk) begin
		if (reset || clear) begin
			elapsed <= 14'h0000;
		end else if (run && tick && elapsed < limit) begin
			elapsed <= elapsed + 14'h0001;
		end
	end

	assign done = (elapsed >= limit);
endmodule : pt_timer

// *** sim/pt_blocks_tb_top.sv ***
// Self-checking bench for the controller function blocks
module pt_blocks_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import pt_pkg::*;
	localparam int TK = 4;
	logic sys_clk = 1'b0, reset = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dwr = 32'h0000_0000, drd, q;
	logic sqw_en = 0, sqw_rst = 0, lod_trg = 0, lod_rst = 0;
	logic up_rst = 0, dn_rst = 0, spt_trg = 0, spt_rst = 0;
	logic up_go = 0, dn_go = 0, up_p, dn_p, up_b, dn_b;
	logic [7:0] up_n = 8'h00, dn_n = 8'h00;
	logic [95:0] chans = '0;
	logic sqw_o, lod_o, up_o, dn_o, spt_o;
	logic [7:0] op;
	logic [126:0] rel;
	int miscompares = 0, total_checks = 0, cyc_cnt = 0, n, s, a, b;
	integer seed = 32'h16a3;
	always #20 sys_clk = ~sys_clk;
	pt_blocks #(.TICK_CYCLES(TK)) i_dut (.sys_clk(sys_clk), .reset(reset),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack),
		.sqw_enable(sqw_en), .sqw_reset(sqw_rst),
		.lod_trigger_input(lod_trg), .lod_reset(lod_rst),
		.up_count_pulse_input(up_p), .up_reset(up_rst),
		.dn_count_pulse_input(dn_p), .dn_reset(dn_rst),
		.spt_trigger_input(spt_trg), .spt_reset(spt_rst),
		.input_channels(chans), .sqw_out(sqw_o), .lod_out(lod_o),
		.up_out(up_o), .dn_out(dn_o), .spt_out(spt_o),
		.output_points(op), .internal_relay_bits(rel));
	pt_far_end i_up (.sys_clk(sys_clk), .reset(reset), .go(up_go),
		.n(up_n), .pulse(up_p), .busy(up_b));
	pt_far_end i_dn (.sys_clk(sys_clk), .reset(reset), .go(dn_go),
		.n(dn_n), .pulse(dn_p), .busy(dn_b));

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			miscompares++;
			final_report();
		end
	end
	task automatic fail(input string m);
		miscompares++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : fail
	task automatic chk_bit(input logic g, input logic e, input string m);
		total_checks++;
		if (g !== e) fail(m);
	endtask : chk_bit
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e,
		input string m);
		total_checks++;
		if (g !== e) fail(m);
	endtask : chk_word
	task automatic chk_len(input int g, input int lo, input int hi,
		input string m);
		total_checks++;
		if (g < lo || g > hi) fail(m);
	endtask : chk_len
	task automatic clk(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : clk
	task automatic wb(input logic w, input logic [7:0] ad,
		input logic [31:0] d, output logic [31:0] r);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= ad;
		sel <= 4'hF;
		dwr <= d;
		do begin
			@(posedge sys_clk);
			t++;
		end while (ack !== 1'b1 && t < 50);
		if (t >= 50) fail("bus timeout");
		r = drd;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		@(posedge sys_clk);
	endtask : wb
	function automatic logic out_of(input int k);
		case (k)
			0: return sqw_o;
			1: return lod_o;
			2: return up_o;
			3: return dn_o;
			default: return spt_o;
		endcase
	endfunction : out_of
	task automatic meas(input int k, input logic v, output int c);
		c = 0;
		while (out_of(k) !== v && c < 500) begin
			@(posedge sys_clk);
			c++;
		end
	endtask : meas
	task automatic pulses(input logic up, input int k);
		up_n <= 8'(k);
		dn_n <= 8'(k);
		if (up) up_go <= 1'b1; else dn_go <= 1'b1;
		clk(1);
		up_go <= 1'b0;
		dn_go <= 1'b0;
		clk(1);
		while (up_b || dn_b) clk(1);
		clk(2);
	endtask : pulses
	function automatic logic [31:0] tcfg(input int v);
		return {13'h0, UNIT_SEC, 2'b00, 14'(v)};
	endfunction : tcfg
	function automatic logic rel_exp(input int x, input int y, input int r);
		case (r)
			0: return x > y;
			1: return x < y;
			2: return x >= y;
			default: return x <= y;
		endcase
	endfunction : rel_exp

	initial begin
		clk(20);
		reset <= 1'b0;
		clk(1);
		wb(0, A_SQW_CFG, 0, q);
		chk_word(q, RST_TIME_CFG, "time cfg reset");
		wb(0, 8'h40, 0, q);
		chk_word(q, 32'h0000_0000, "unmapped read");
		for (int i = 0; i < 3; i++) begin
			wb(1, 8'(4 * i), tcfg(16'h3FFF), q);
			wb(0, 8'(4 * i), 0, q);
			chk_word(q, tcfg(16'h3FFF), "time cfg top");
			wb(1, 8'(4 * i), tcfg(0), q);
			wb(0, 8'(4 * i), 0, q);
			chk_word(q, tcfg(0), "time cfg bottom");
		end
		wb(1, A_UP_TARGET, 32'h000F_FFFF, q);
		wb(0, A_UP_TARGET, 0, q);
		chk_word(q, 32'h000F_FFFF, "target top");
		$display("test registers done");
		s = 2 + ($unsigned($random(seed)) % 6);
		wb(1, A_UP_TARGET, s, q);
		pulses(1, s - 1);
		chk_bit(up_o, 1'b0, "up early");
		wb(0, A_UP_COUNT, 0, q);
		chk_word(q, s - 1, "up count");
		pulses(1, 1);
		chk_bit(up_o, 1'b1, "up at target");
		up_rst <= 1'b1;
		pulses(1, 2);
		chk_bit(up_o, 1'b0, "up reset out");
		wb(0, A_UP_COUNT, 0, q);
		chk_word(q, 0, "up reset count");
		up_rst <= 1'b0;
		wb(1, A_DN_PRESET, s, q);
		clk(3);
		pulses(0, s - 1);
		chk_bit(dn_o, 1'b0, "down early");
		wb(0, A_DN_COUNT, 0, q);
		chk_word(q, 1, "down count");
		pulses(0, 1);
		chk_bit(dn_o, 1'b1, "down at zero");
		dn_rst <= 1'b1;
		clk(2);
		chk_bit(dn_o, 1'b0, "down reset");
		dn_rst <= 1'b0;
		$display("test counters done");
		for (int i = 0; i < 2; i++) begin
			// First pass: a zero setting must act as one hundredth
			s = (i == 0) ? 0 : 1 + ($unsigned($random(seed)) % 8);
			b = (s == 0) ? 1 : s;
			wb(1, A_SPT_CFG, tcfg(s), q);
			spt_trg <= 1'b1;
			meas(4, 1'b1, n);
			chk_len(n, 1, 2, "pulse start");
			spt_trg <= 1'b0;
			meas(4, 1'b0, n);
			chk_len(n, (b - 1) * TK - 1, b * TK + 2, "pulse width");
		end
		spt_trg <= 1'b1;
		clk(2);
		spt_rst <= 1'b1;
		spt_trg <= 1'b0;
		clk(2);
		chk_bit(spt_o, 1'b0, "pulse cut");
		spt_rst <= 1'b0;
		$display("test pulse done");
		s = 3;
		wb(1, A_LOD_CFG, tcfg(s), q);
		lod_trg <= 1'b1;
		meas(1, 1'b1, n);
		chk_len(n, (s - 1) * TK, s * TK + 3, "delay");
		repeat (3) begin
			lod_trg <= ~lod_trg;
			clk(2);
		end
		chk_bit(lod_o, 1'b1, "latched");
		lod_rst <= 1'b1;
		lod_trg <= 1'b0;
		clk(2);
		chk_bit(lod_o, 1'b0, "latch clear");
		lod_trg <= 1'b1;
		clk(s * TK + 8);
		chk_bit(lod_o, 1'b0, "reset wins");
		lod_rst <= 1'b0;
		lod_trg <= 1'b0;
		$display("test on-delay done");
		wb(1, A_SQW_CFG, tcfg(s), q);
		sqw_en <= 1'b1;
		meas(0, 1'b1, n);
		chk_len(n, (s - 1) * TK, s * TK + 3, "first high");
		meas(0, 1'b0, n);
		chk_len(n, (s - 1) * TK, s * TK + 2, "half period");
		clk(s * TK + 2);
		sqw_en <= 1'b0;
		clk(2);
		chk_bit(sqw_o, 1'b0, "halt low");
		sqw_en <= 1'b1;
		sqw_rst <= 1'b1;
		clk(s * TK * 3);
		chk_bit(sqw_o, 1'b0, "reset low");
		sqw_rst <= 1'b0;
		meas(0, 1'b1, n);
		chk_len(n, (s - 1) * TK, s * TK + 3, "restart");
		sqw_en <= 1'b0;
		$display("test generator done");
		wb(1, A_CMP_ROUTE, 32'h0000_0002, q);
		for (int r = 0; r < 4; r++) begin
			a = $unsigned($random(seed)) % 101;
			b = (r == 2) ? a : $unsigned($random(seed)) % 101;
			// Odd relations take operand two from channel one
			chans <= {$random(seed), $random(seed), 16'h0, 8'(b), 8'(a)};
			wb(1, A_CMP_CFG, {6'h00, 2'(r), 4'h1, 1'(r % 2), 7'(b),
				12'h080}, q);
			clk(3);
			chk_bit(op[2], rel_exp(a, b, r), "compare");
		end
		s = $unsigned($random(seed)) % 127;
		wb(1, A_CMP_ROUTE, 8 + s, q);
		clk(3);
		chk_bit(rel[s], rel_exp(a, b, 3), "relay route");
		chk_bit(op[2], 1'b0, "old point free");
		$display("test comparator done");
		final_report();
	end
endmodule : pt_blocks_tb_top

// *** sim/pt_far_end.sv ***
// Far-side source of count pulses, one low sample after each high one
module pt_far_end (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// Request and pulse train
	input  wire logic       go,
	input  wire logic [7:0] n,
	output logic            pulse,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] left_reg;
	assign busy = (left_reg != 9'h000);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			left_reg <= 9'h000;
			pulse    <= 1'b0;
		end else if (go && !busy) begin
			left_reg <= {n, 1'b0};
		end else if (busy) begin
			left_reg <= left_reg - 9'h001;
			pulse    <= ~left_reg[0];
		end else begin
			pulse    <= 1'b0;
		end
	end
endmodule : pt_far_end
